/* core/i2c_ctrl_pkg.sv */
// Constants for the I2C control channel configuration block
package i2c_ctrl_pkg;

  // Register offsets
  localparam logic [7:0] OFS_PASS_TIMING = 8'h21;
  localparam logic [7:0] OFS_ERR_WD      = 8'h22;
  localparam logic [7:0] OFS_SCRATCH     = 8'h23;

  // Reset values
  localparam logic [7:0] RST_PASS_TIMING = 8'h17;
  localparam logic [7:0] RST_ERR_WD      = 8'h00;
  localparam logic [7:0] RST_SCRATCH     = 8'h00;

  // Field positions, pass and timing register
  localparam int BIT_PASS_ALL  = 7;
  localparam int POS_HOLD_HI   = 6;
  localparam int POS_HOLD_LO   = 4;
  localparam int POS_FILT_HI   = 3;
  localparam int POS_FILT_LO   = 0;

  // Field positions, error and watchdog register
  localparam int BIT_SEQ_ERR   = 7;
  localparam int BIT_SEQ_CLR   = 6;
  localparam int POS_ODLY_HI   = 4;
  localparam int POS_ODLY_LO   = 3;
  localparam int BIT_WR_BLOCK  = 2;
  localparam int BIT_WD_FAST   = 1;
  localparam int BIT_WD_OFF    = 0;

  // Timing figures
  localparam int CLK_PERIOD_PS = 5000;
  localparam int HOLD_STEP_NS  = 50;
  localparam int FILT_STEP_NS  = 10;
  localparam int ODLY_BASE_NS  = 350;
  localparam int ODLY_STEP_NS  = 50;
  localparam int WD_FAST_US    = 50;
  localparam int WD_SLOW_S     = 1;
  localparam int RECOV_HALF_US = 5;

  // Derived cycle counts
  localparam int HOLD_STEP_CYC = (HOLD_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FILT_STEP_CYC = (FILT_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ODLY_BASE_CYC = (ODLY_BASE_NS * 1000) / CLK_PERIOD_PS;
  localparam int ODLY_STEP_CYC = (ODLY_STEP_NS * 1000) / CLK_PERIOD_PS;
  localparam int WD_FAST_CYC   = (WD_FAST_US * 1000000) / CLK_PERIOD_PS;
  localparam int WD_SLOW_CYC   = (WD_SLOW_S * 200000000);
  localparam int RECOV_HALF_CYC = (RECOV_HALF_US * 1000000) / CLK_PERIOD_PS;
  localparam int RECOV_PULSES  = 9;
  localparam int HOLD_MAX_CYC  = 7 * HOLD_STEP_CYC;
  localparam int ODLY_MAX_CYC  = ODLY_BASE_CYC + 3 * ODLY_STEP_CYC;

  // Watchdog recovery states
  typedef enum logic [1:0]
  {
    WD_WATCH   = 2'b00,
    WD_PULL    = 2'b01,
    WD_RELEASE = 2'b11
  } wd_state_type;

endpackage

/* core/i2c_control_channel_config.sv */
// I2C control channel pass-through, timing, error and watchdog logic
// Operation
// - With pass-all set, every access not aimed at the own ID is forwarded under the remap ID.
// - With pass-all clear, only accesses aimed at the serializer or remote slave ID go through.
// - Bits 6:4 set the SDA input hold relative to SCL in 50 ns steps.
// - Bits 3:0 set the longest rejected SCL and SDA glitch in 10 ns steps.
// - Status bit 7 reads 1 once a forward channel sequence error is seen, else 0.
// - Writing 1 to bit 6 clears the sequence error status.
// - Bits 4:3 select SDA output delay of 350 ns plus 50 ns per count.
// - With bit 2 set, register writes arriving from the remote side are ignored.
// - The write block never affects forwarding to slaves behind this device.
// - Bit 1 selects a watchdog timeout of about 50 us when set, about 1 s when clear.
// - An enabled watchdog that times out with SDA high marks the bus free.
// - A timeout with SDA low drives 9 clock pulses on SCL to release the bus.
// - Bit 0 disables the watchdog when 1 and enables it when 0.
// - An 8-bit scratch register returns the last value written.
`timescale 1ns/1ps
module i2c_control_channel_config
  import i2c_ctrl_pkg::*;
#(
  parameter int WD_FAST_LIMIT = i2c_ctrl_pkg::WD_FAST_CYC,
  parameter int WD_SLOW_LIMIT = i2c_ctrl_pkg::WD_SLOW_CYC
)
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Register access port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_remote,
  output logic      [7:0] reg_rdata_r,
  // Address routing
  input  wire logic       tgt_valid,
  input  wire logic [6:0] tgt_id,
  input  wire logic [6:0] own_id,
  input  wire logic [6:0] ser_id,
  input  wire logic [6:0] slave_id,
  input  wire logic [6:0] remap_id,
  output logic            fwd_valid_r,
  output logic      [6:0] fwd_id_r,
  // Control channel error
  input  wire logic       seq_err_event,
  // Bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       sda_drive_req,
  output logic            scl_filt_r,
  output logic            sda_filt_r,
  output logic            sda_held_r,
  output logic            sda_oe_r,
  output logic            scl_oe_r,
  output logic            scl_out_r,
  output logic            bus_free_r
);
  import i2c_ctrl_pkg::*;
  logic [7:0]   pass_timing_r;
  logic [4:0]   ctrl_low_r;
  logic         seq_err_r;
  logic [7:0]   scratch_r;
  logic         wr_ok;
  logic         wd_off;
  logic [2:0]   hold_sel;
  logic [3:0]   filt_sel;
  logic [1:0]   odly_sel;
  logic [1:0]   raw_pins;
  logic [1:0]   filt_pins;
  logic [1:0]   prev_pins_r;
  logic [HOLD_MAX_CYC:0] hold_line_r;
  logic [ODLY_MAX_CYC:0] odly_line_r;
  logic [27:0]  idle_cnt_r;
  logic [27:0]  wd_limit;
  logic [15:0]  half_cnt_r;
  logic [3:0]   pulse_cnt_r;
  wd_state_type wd_state_r;

  assign wr_ok    = reg_wr && !(reg_remote && ctrl_low_r[BIT_WR_BLOCK]);
  assign wd_off   = ctrl_low_r[BIT_WD_OFF];
  assign hold_sel = pass_timing_r[POS_HOLD_HI:POS_HOLD_LO];
  assign filt_sel = pass_timing_r[POS_FILT_HI:POS_FILT_LO];
  assign odly_sel = ctrl_low_r[POS_ODLY_HI:POS_ODLY_LO];
  assign raw_pins = {sda_in, scl_in};
  assign filt_pins = {sda_filt_r, scl_filt_r};
  assign wd_limit = ctrl_low_r[BIT_WD_FAST] ? 28'(WD_FAST_LIMIT) : 28'(WD_SLOW_LIMIT);
  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pass_timing_r <= RST_PASS_TIMING;
      ctrl_low_r    <= RST_ERR_WD[4:0];
      scratch_r     <= RST_SCRATCH;
    end
    else if (wr_ok)
    begin
      if (reg_addr == OFS_PASS_TIMING)
        pass_timing_r <= reg_wdata;
      if (reg_addr == OFS_ERR_WD)
        ctrl_low_r <= {reg_wdata[4:3], reg_wdata[2:0]};
      if (reg_addr == OFS_SCRATCH)
        scratch_r <= reg_wdata;
    end
  end

  // Sequence error flag, set wins over clear
  always_ff @(posedge clock)
  begin
    if (rst)
      seq_err_r <= 1'b0;
    else if (seq_err_event)
      seq_err_r <= 1'b1;
    else if (wr_ok && reg_addr == OFS_ERR_WD && reg_wdata[BIT_SEQ_CLR])
      seq_err_r <= 1'b0;
  end

  // Register reads
  always_ff @(posedge clock)
  begin
    if (rst)
      reg_rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFS_PASS_TIMING: reg_rdata_r <= pass_timing_r;
        OFS_ERR_WD:      reg_rdata_r <= {seq_err_r, 2'b00, ctrl_low_r};
        OFS_SCRATCH:     reg_rdata_r <= scratch_r;
        default:         reg_rdata_r <= 8'h00;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Pass-through decision, independent of the write block
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      fwd_valid_r <= 1'b0;
      fwd_id_r    <= 7'h00;
    end
    else
    begin
      fwd_valid_r <= 1'b0;
      if (tgt_valid && tgt_id != own_id)
      begin
        if (pass_timing_r[BIT_PASS_ALL])
        begin
          fwd_valid_r <= 1'b1;
          fwd_id_r    <= remap_id;
        end
        else if (tgt_id == ser_id || tgt_id == slave_id)
        begin
          fwd_valid_r <= 1'b1;
          fwd_id_r    <= tgt_id;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Glitch filters for SCL and SDA
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_filt
      logic [5:0] stab_cnt_r;
      logic       filt_r;
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          stab_cnt_r <= 6'h00;
          filt_r     <= 1'b1;
        end
        else if (raw_pins[g] == filt_r)
          stab_cnt_r <= 6'h00;
        else if (stab_cnt_r >= 6'(filt_sel * FILT_STEP_CYC))
        begin
          filt_r     <= raw_pins[g];
          stab_cnt_r <= 6'h00;
        end
        else
          stab_cnt_r <= stab_cnt_r + 6'h01;
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      scl_filt_r <= 1'b1;
      sda_filt_r <= 1'b1;
    end
    else
    begin
      scl_filt_r <= gen_filt[0].filt_r;
      sda_filt_r <= gen_filt[1].filt_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // SDA input hold and SDA output delay lines
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      hold_line_r <= '1;
      odly_line_r <= '0;
      sda_held_r  <= 1'b1;
      sda_oe_r    <= 1'b0;
    end
    else
    begin
      hold_line_r <= {hold_line_r[HOLD_MAX_CYC-1:0], sda_filt_r};
      odly_line_r <= {odly_line_r[ODLY_MAX_CYC-1:0], sda_drive_req};
      sda_held_r  <= hold_line_r[hold_sel * HOLD_STEP_CYC];
      sda_oe_r    <= odly_line_r[ODLY_BASE_CYC + odly_sel * ODLY_STEP_CYC];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus watchdog
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prev_pins_r <= 2'b11;
      idle_cnt_r  <= 28'h0000000;
    end
    else
    begin
      prev_pins_r <= filt_pins;
      if (wd_off || wd_state_r != WD_WATCH || filt_pins != prev_pins_r)
        idle_cnt_r <= 28'h0000000;
      else if (idle_cnt_r < wd_limit)
        idle_cnt_r <= idle_cnt_r + 28'h0000001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wd_state_r  <= WD_WATCH;
      half_cnt_r  <= 16'h0000;
      pulse_cnt_r <= 4'h0;
      scl_oe_r    <= 1'b0;
      scl_out_r   <= 1'b0;
      bus_free_r  <= 1'b0;
    end
    else
    begin
      case (wd_state_r)
        WD_WATCH:
        begin
          scl_oe_r    <= 1'b0;
          pulse_cnt_r <= 4'h0;
          half_cnt_r  <= 16'h0000;
          if (wd_off || filt_pins != prev_pins_r)
            bus_free_r <= 1'b0;
          else if (idle_cnt_r >= wd_limit && sda_filt_r)
            bus_free_r <= 1'b1;
          else if (idle_cnt_r >= wd_limit)
          begin
            wd_state_r <= WD_PULL;
            scl_oe_r   <= 1'b1;
          end
        end
        WD_PULL:
        begin
          if (half_cnt_r >= 16'(RECOV_HALF_CYC - 1))
          begin
            half_cnt_r  <= 16'h0000;
            scl_oe_r    <= 1'b0;
            pulse_cnt_r <= pulse_cnt_r + 4'h1;
            wd_state_r  <= WD_RELEASE;
          end
          else
            half_cnt_r <= half_cnt_r + 16'h0001;
        end
        WD_RELEASE:
        begin
          if (half_cnt_r >= 16'(RECOV_HALF_CYC - 1))
          begin
            half_cnt_r <= 16'h0000;
            if (pulse_cnt_r >= 4'(RECOV_PULSES))
              wd_state_r <= WD_WATCH;
            else
            begin
              scl_oe_r   <= 1'b1;
              wd_state_r <= WD_PULL;
            end
          end
          else
            half_cnt_r <= half_cnt_r + 16'h0001;
        end
        default:
          wd_state_r <= WD_WATCH;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  pass_all_a: assert property (@(posedge clock) disable iff (rst)
    tgt_valid && tgt_id != own_id && pass_timing_r[BIT_PASS_ALL]
    |=> fwd_valid_r && fwd_id_r == $past(remap_id))
    else $error("pass-all access not remapped");
  pass_match_a: assert property (@(posedge clock) disable iff (rst)
    tgt_valid && !pass_timing_r[BIT_PASS_ALL] && tgt_id != own_id
    |=> fwd_valid_r == $past(tgt_id == ser_id || tgt_id == slave_id))
    else $error("selective pass-through wrong");
  own_id_a: assert property (@(posedge clock) disable iff (rst)
    tgt_valid && tgt_id == own_id |=> !fwd_valid_r)
    else $error("own ID access forwarded");
  seq_set_a: assert property (@(posedge clock) disable iff (rst)
    seq_err_event |=> seq_err_r ##1 (seq_err_r || $past(reg_wr)))
    else $error("sequence error not flagged");
  seq_clear_a: assert property (@(posedge clock) disable iff (rst)
    wr_ok && reg_addr == OFS_ERR_WD && reg_wdata[BIT_SEQ_CLR] && !seq_err_event
    |=> !seq_err_r)
    else $error("sequence error not cleared");
  write_block_a: assert property (@(posedge clock) disable iff (rst)
    reg_wr && reg_remote && ctrl_low_r[BIT_WR_BLOCK] |=> $stable(scratch_r)
    && $stable(pass_timing_r))
    else $error("remote write not blocked");
  scratch_echo_a: assert property (@(posedge clock) disable iff (rst)
    wr_ok && reg_addr == OFS_SCRATCH |=> scratch_r == $past(reg_wdata))
    else $error("scratch value lost");
  wd_disable_a: assert property (@(posedge clock) disable iff (rst)
    wd_off && wd_state_r == WD_WATCH |=> idle_cnt_r == 28'h0000000 && !bus_free_r)
    else $error("disabled watchdog still active");
  bus_free_a: assert property (@(posedge clock) disable iff (rst)
    wd_state_r == WD_WATCH && !wd_off && idle_cnt_r >= wd_limit && sda_filt_r
    && filt_pins == prev_pins_r |=> bus_free_r)
    else $error("free bus not detected");
  pulse_count_a: assert property (@(posedge clock) disable iff (rst)
    pulse_cnt_r <= 4'(RECOV_PULSES))
    else $error("too many recovery pulses");
endmodule

/* tb/bus_partner.sv */
// Open-drain I2C wire model with a slave that can hang SDA low
`timescale 1ns/1ps
module bus_partner
(
  // Clock
  input  wire logic clock,
  // Bench controls
  input  wire logic hang,
  input  wire logic sda_pull,
  input  wire logic scl_drv,
  // Device enables
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // Wire levels
  output logic      scl_line,
  output logic      sda_line
);
  logic       scl_q;
  logic [3:0] fall_cnt;
  logic       stuck;
  ////////////////////////////////////////////////////////////////////////////////
  // Pull-ups, any party pulls low
  assign scl_line = scl_drv & ~scl_oe;
  assign stuck    = hang && (fall_cnt < 4'h9);
  assign sda_line = ~(sda_oe | sda_pull | stuck);
  ////////////////////////////////////////////////////////////////////////////////
  // Hung slave lets go after nine SCL falls
  always_ff @(posedge clock)
  begin
    scl_q <= scl_line;
    if (!hang)
      fall_cnt <= 4'h0;
    else if (scl_q && !scl_line && stuck)
      fall_cnt <= fall_cnt + 4'h1;
  end
endmodule

/* tb/i2c_control_channel_config_bench.sv */
// Self-checking bench for the I2C control channel configuration block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module i2c_control_channel_config_bench;
  import i2c_ctrl_pkg::*;
  logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, reg_remote = 0, tgt_valid = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_r, v, e;
  logic [6:0] tgt_id = 7'h00, fwd_id_r, id, eid;
  logic [6:0] own_id = 7'h3A, ser_id = 7'h12, slave_id = 7'h50, remap_id = 7'h44;
  logic fwd_valid_r, seq_err_event = 0, scl_in, sda_in, sda_drive_req = 0;
  logic scl_filt_r, sda_filt_r, sda_held_r, sda_oe_r, scl_oe_r, bus_free_r, rd_d = 0;
  logic scl_out_r;
  logic hang = 0, sda_pull = 0, scl_drv = 1, g, ok, prev;
  logic [31:0] seed = 32'd21964;
  logic [7:0] rq[$];
  logic [6:0] fq[$];
  int failures = 0, cmp_count = 0, cycles = 0, n, m, p;
  int fl[3] = '{0, 15, 5};
  int hl[3] = '{0, 7, 3};
  always #2.5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  i2c_control_channel_config #(.WD_FAST_LIMIT(100), .WD_SLOW_LIMIT(300)) dut
  (
    .clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_remote(reg_remote), .reg_rdata_r(reg_rdata_r),
    .tgt_valid(tgt_valid), .tgt_id(tgt_id), .own_id(own_id), .ser_id(ser_id),
    .slave_id(slave_id), .remap_id(remap_id), .fwd_valid_r(fwd_valid_r),
    .fwd_id_r(fwd_id_r), .seq_err_event(seq_err_event), .scl_in(scl_in), .sda_in(sda_in),
    .sda_drive_req(sda_drive_req), .scl_filt_r(scl_filt_r), .sda_filt_r(sda_filt_r),
    .sda_held_r(sda_held_r), .sda_oe_r(sda_oe_r), .scl_oe_r(scl_oe_r), .scl_out_r(scl_out_r),
    .bus_free_r(bus_free_r)
  );
  bus_partner far_side
  (
    .clock(clock), .hang(hang), .sda_pull(sda_pull), .scl_drv(scl_drv),
    .scl_oe(scl_oe_r), .sda_oe(sda_oe_r), .scl_line(scl_in), .sda_line(sda_in)
  );
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic sig(input int k);
    return (k == 0) ? sda_oe_r : (k == 1) ? sda_filt_r : (k == 2) ? sda_held_r : bus_free_r;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rem);
    @(negedge clock);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    reg_remote = rem;
    @(negedge clock);
    reg_wr = 0;
    reg_remote = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(negedge clock);
    reg_rd = 1;
    reg_addr = a;
    rq.push_back(x);
    @(negedge clock);
    reg_rd = 0;
  endtask
  task automatic route(input logic [6:0] t, input logic f, input logic [6:0] x);
    @(negedge clock);
    tgt_valid = 1;
    tgt_id = t;
    if (f)
      fq.push_back(x);
    @(negedge clock);
    tgt_valid = 0;
  endtask
  task automatic meas(input int k, input logic lvl, output int c);
    c = 0;
    while (sig(k) !== lvl && c < 3000)
    begin
      @(negedge clock);
      c++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Output watcher
  always @(posedge clock)
    rd_d <= reg_rd;
  always @(negedge clock)
  begin
    if (rd_d)
    begin
      e = rq.pop_front();
      `CHK("rdata", e, reg_rdata_r)
    end
    if (fwd_valid_r === 1'b1 && fq.size() == 0)
      `CHK("fwd_pulse", 1'b0, fwd_valid_r)
    else if (fwd_valid_r === 1'b1)
    begin
      eid = fq.pop_front();
      `CHK("fwd_id", eid, fwd_id_r)
    end
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst = 0;
    rd(OFS_PASS_TIMING, 8'h17);
    rd(OFS_ERR_WD, 8'h00);
    rd(OFS_SCRATCH, 8'h00);
    rd(8'h30, 8'h00);
    v = rnd();
    wr(OFS_SCRATCH, v, 1);
    wr(8'h30, 8'hFF, 0);
    rd(8'h30, 8'h00);
    rd(OFS_SCRATCH, v);
    wr(OFS_ERR_WD, 8'h04, 0);
    wr(OFS_SCRATCH, ~v, 1);
    wr(OFS_ERR_WD, 8'h00, 1);
    rd(OFS_SCRATCH, v);
    rd(OFS_ERR_WD, 8'h04);
    route(ser_id, 1, ser_id);
    route(slave_id, 1, slave_id);
    for (int pa = 0; pa < 2; pa++)
    begin
      wr(OFS_PASS_TIMING, {pa[0], 7'h17}, 0);
      for (int k = 0; k < 6; k++)
      begin
        v = rnd();
        id = (k == 0) ? ser_id : (k == 1) ? slave_id : (k == 2) ? own_id : v[6:0];
        ok = (id != own_id) && (pa == 1 || id == ser_id || id == slave_id);
        route(id, ok, (pa == 1) ? remap_id : id);
      end
    end
    wr(OFS_ERR_WD, 8'h00, 0);
    rd(OFS_ERR_WD, 8'h00);
    @(negedge clock);
    seq_err_event = 1;
    @(negedge clock);
    seq_err_event = 0;
    rd(OFS_ERR_WD, 8'h80);
    wr(OFS_ERR_WD, 8'h40, 0);
    rd(OFS_ERR_WD, 8'h00);
    @(negedge clock);
    seq_err_event = 1;
    reg_wr = 1;
    reg_addr = OFS_ERR_WD;
    reg_wdata = 8'h40;
    @(negedge clock);
    seq_err_event = 0;
    reg_wr = 0;
    rd(OFS_ERR_WD, 8'h80);
    wr(OFS_ERR_WD, 8'hFF, 0);
    rd(OFS_ERR_WD, 8'h1F);
    for (int s = 0; s < 4; s++)
    begin
      wr(OFS_ERR_WD, 8'(s << 3), 0);
      @(negedge clock);
      sda_drive_req = 1;
      meas(0, 1'b1, n);
      `CHK("out_delay", 72 + 10 * s, n)
      sda_drive_req = 0;
      repeat (120) @(negedge clock);
    end
    for (int k = 0; k < 3; k++)
    begin
      v = {1'b0, 3'(hl[k]), 4'(fl[k])};
      wr(OFS_PASS_TIMING, v, 0);
      rd(OFS_PASS_TIMING, v);
      repeat (40) @(negedge clock);
      g = 1;
      sda_pull = (fl[k] > 0);
      for (int i = 0; i < 2 * fl[k] + 4; i++)
      begin
        @(negedge clock);
        if (i == 2 * fl[k] - 1)
          sda_pull = 0;
        g = g & sda_filt_r;
      end
      `CHK("glitch", 1'b1, g)
      sda_pull = 1;
      meas(1, 1'b0, n);
      `CHK("filter", 2 * fl[k] + 2, n)
      meas(2, 1'b0, m);
      `CHK("hold", 10 * hl[k] + 2, m)
      sda_pull = 0;
      repeat (120) @(negedge clock);
    end
    wr(OFS_ERR_WD, 8'h01, 0);
    hang = 1;
    g = 0;
    repeat (600)
    begin
      @(negedge clock);
      g = g | scl_oe_r;
    end
    `CHK("wd_off", 1'b0, g)
    wr(OFS_ERR_WD, 8'h02, 0);
    p = 0;
    prev = 0;
    g = 0;
    for (int i = 0; i < 30000 && bus_free_r !== 1'b1; i++)
    begin
      @(negedge clock);
      p += (scl_oe_r === 1'b1 && !prev);
      prev = scl_oe_r;
      g = g | (scl_out_r !== 1'b0);
    end
    `CHK("pulses", 9, p)
    `CHK("scl_out", 1'b0, g)
    `CHK("free", 1'b1, bus_free_r)
    hang = 0;
    for (int s = 0; s < 2; s++)
    begin
      wr(OFS_ERR_WD, (s == 0) ? 8'h02 : 8'h00, 0);
      repeat (400) @(negedge clock);
      scl_drv = 0;
      repeat (40) @(negedge clock);
      `CHK("busy", 1'b0, bus_free_r)
      `CHK("scl_filt", 1'b0, scl_filt_r)
      scl_drv = 1;
      meas(3, 1'b1, n);
      ok = (n >= ((s == 0) ? 100 : 300)) && (n < ((s == 0) ? 140 : 340));
      `CHK("wd_time", 1'b1, ok)
    end
    repeat (4) @(negedge clock);
    `CHK("fwd_left", 0, fq.size())
    report_and_stop();
  end
endmodule
